// ===== verif/testbench.sv
// Self-checking bench for the timer mode and capture/compare block
// Assumes the APB slave answers after one access cycle or more
`default_nettype none
`include "tmc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk;
  logic                     rstn;
  tmc_pkg::tmc_apb_req_type req;
  tmc_pkg::tmc_apb_rsp_type rsp;
  logic                     pri, sec, tout, irq0, irq1, perr, pri_q, sec_q, tout_q;
  logic [31:0]              rnd, v, a, b;
  int                       err_total, checked, cyc, n0, n1, nt, last0, per0, c0, c1;
  int                       qp[$], qf[$], qs[$];

  tmc_timer tmc_timer_i (.core_clk_i(clk), .rstn_i(rstn), .apb_req_i(req), .apb_rsp_o(rsp),
    .primary_input_pin_i(pri), .secondary_input_pin_i(sec), .timer_output_pin_o(tout),
    .first_match_irq_o(irq0), .second_match_irq_o(irq1));
  tmc_pin_drv tmc_pin_drv_i (.clk_i(clk), .pri_o(pri), .sec_o(sec));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sampled mid-cycle, clear of the edge updates
  always @(negedge clk) begin
    if (irq0 === 1'b1) begin
      n0++;
      per0 = cyc - last0;
      last0 = cyc;
    end
    if (irq1 === 1'b1) n1++;
    if (tout !== tout_q) nt++;
    if (pri && !pri_q) qp.push_back(cyc);
    if (!pri && pri_q) qf.push_back(cyc);
    if (sec && !sec_q) qs.push_back(cyc);
    tout_q = tout;
    pri_q = pri;
    sec_q = sec;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      test_done();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] x, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {x, 2'b00}, pwdata: d, pstrb: 4'hF};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    v = rsp.prdata;
    perr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic clr();
    n0 = 0;
    n1 = 0;
    nt = 0;
  endtask
  // Stop first, then reconfigure and start
  task automatic cfg(input logic [7:0] cc, input logic [7:0] ed, input logic [7:0] md);
    apb(1'b1, `TMC_IDX_MODE, 32'h0);
    apb(1'b1, `TMC_IDX_CCCTL, {24'h0, cc});
    apb(1'b1, `TMC_IDX_EDGE, {24'h0, ed});
    clr();
    apb(1'b1, `TMC_IDX_MODE, {24'h0, md});
  endtask
  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    req = '0;
    rnd = 32'hBA2110E1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, `TMC_IDX_MODE, 32'h0);
    chk("mode reset", v, 32'h0);
    apb(1'b0, `TMC_IDX_CCCTL, 32'h0);
    chk("ctl reset", v, 32'h0);
    apb(1'b0, 16'hFF70, 32'h0);
    chk("unmapped error", {31'h0, perr}, 32'h1);
    apb(1'b1, `TMC_IDX_CCCTL, 32'hFF);
    apb(1'b0, `TMC_IDX_CCCTL, 32'h0);
    chk("ctl upper bits", v, 32'h7);
    apb(1'b1, `TMC_IDX_MODE, 32'hF2);
    apb(1'b0, `TMC_IDX_MODE, 32'h0);
    chk("mode upper bits", v, 32'h2);
    apb(1'b0, `TMC_IDX_COUNT, 32'h0);
    chk("stopped count", v, 32'h0);
    $display("Test registers done");
    rnd = lfsr(rnd);
    c0 = 16 + rnd[5:0];
    c1 = c0 + 10 + rnd[10:6];
    apb(1'b1, `TMC_IDX_CAP0, 32'(c0));
    apb(1'b1, `TMC_IDX_CAP1, 32'(c1));
    cfg(8'h00, 8'h00, 8'h04);
    repeat (c1 + 20) @(posedge clk);
    apb(1'b1, `TMC_IDX_MODE, 32'h0);
    chk("free first irq", 32'(n0), 32'h1);
    chk("free second irq", 32'(n1), 32'h1);
    chk("free toggles", 32'(nt), 32'h2);
    clr();
    repeat (50) @(posedge clk);
    chk("stop no irq", 32'(n0 + n1 + nt), 32'h0);
    cfg(8'h00, 8'h00, 8'h0C);
    repeat (3 * c0 + 30) @(posedge clk);
    chk("match period", 32'(per0), 32'(c0 + 1));
    chk("no second irq", 32'(n1), 32'h0);
    chk("match toggles", 32'(nt), 32'(n0));
    $display("Test count modes done");
    apb(1'b1, `TMC_IDX_CAP0, 32'hFFF0);
    apb(1'b1, `TMC_IDX_CAP1, 32'hFFF0);
    cfg(8'h00, 8'h10, 8'h0A);
    repeat (60) @(posedge clk);
    tmc_pin_drv_i.pulse(1'b0, 4);
    repeat (10) @(posedge clk);
    apb(1'b0, `TMC_IDX_COUNT, 32'h0);
    chk("edge clear", {31'h0, v < 32'd40}, 32'h1);
    chk("edge toggle", 32'(nt), 32'h1);
    rnd = lfsr(rnd);
    cfg(8'h07, 8'h10, 8'h04);
    repeat (20) @(posedge clk);
    tmc_pin_drv_i.pulse(1'b0, 3 + rnd[2:0]);
    repeat (10) @(posedge clk);
    apb(1'b0, `TMC_IDX_CAP0, 32'h0);
    a = v;
    apb(1'b0, `TMC_IDX_CAP1, 32'h0);
    b = v;
    chk("reverse capture", a - b, 32'(qf[$] - qp[$]));
    cfg(8'h01, 8'h40, 8'h04);
    tmc_pin_drv_i.pulse(1'b1, 3);
    repeat (8 + rnd[7:3]) @(posedge clk);
    apb(1'b0, `TMC_IDX_CAP0, 32'h0);
    a = v;
    tmc_pin_drv_i.pulse(1'b1, 3);
    repeat (10) @(posedge clk);
    apb(1'b0, `TMC_IDX_CAP0, 32'h0);
    chk("secondary capture", v - a, 32'(qs[$] - qs[$-1]));
    a = v;
    cfg(8'h07, 8'h30, 8'h04);
    tmc_pin_drv_i.pulse(1'b0, 4);
    repeat (10) @(posedge clk);
    apb(1'b0, `TMC_IDX_CAP0, 32'h0);
    chk("both edges first", v, a);
    apb(1'b0, `TMC_IDX_CAP1, 32'h0);
    chk("both edges second", v, b);
    $display("Test capture done");
    apb(1'b1, `TMC_IDX_CAP0, 32'hFFFF);
    cfg(8'h00, 8'h00, 8'h0C);
    repeat (100) @(posedge clk);
    apb(1'b0, `TMC_IDX_MODE, 32'h0);
    chk("no overflow yet", v, 32'h0C);
    repeat (65536) @(posedge clk);
    apb(1'b0, `TMC_IDX_MODE, 32'h0);
    chk("overflow flag", v, 32'h0D);
    $display("Test overflow done");
    test_done();
  end
endmodule
`default_nettype wire

// ===== verif/tmc_pin_drv.sv
// Far-side model of the two capture pins
// Assumes the bench clock drives it; pins idle low
`default_nettype none
module tmc_pin_drv (
  // Clock
  input  wire logic clk_i,
  // Pins
  output logic      pri_o,
  output logic      sec_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    pri_o = 1'b0;
    sec_o = 1'b0;
  end
  // Width floored at three clocks, shorter pulses may be lost
  task automatic pulse(input bit sel, input int w);
    int n;
    n = (w < 3) ? 3 : w;
    @(posedge clk_i);
    sec_o <= sel;
    pri_o <= !sel;
    repeat (n) @(posedge clk_i);
    sec_o <= 1'b0;
    pri_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verilog/tmc_consts.svh
// Offsets, field positions, reset values and count-clock divider counts
// Assumes word-indexed APB addressing: byte address is four times the index
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

`define TMC_IDX_MODE     16'hFF60
`define TMC_IDX_EDGE     16'hFF61
`define TMC_IDX_CCCTL    16'hFF62
`define TMC_IDX_CAP0     16'hFF64
`define TMC_IDX_CAP1     16'hFF66
`define TMC_IDX_COUNT    16'hFF68

`define TMC_MODE_RST     4'h0
`define TMC_CCCTL_RST    3'h0
`define TMC_EDGE_RST     8'h00

`define TMC_OVF_BIT      0
`define TMC_TOG_BIT      1
`define TMC_CAP0_BIT     0
`define TMC_TRIG_BIT     1
`define TMC_CAP1_BIT     2

`define TMC_OP_STOP      2'h0
`define TMC_OP_FREE      2'h1
`define TMC_OP_CLR_EDGE  2'h2
`define TMC_OP_CLR_MATCH 2'h3

`define TMC_EDGE_FALL    2'h0
`define TMC_EDGE_RISE    2'h1
`define TMC_EDGE_BOTH    2'h3

`define TMC_DIV_MID      8'h03
`define TMC_DIV_SLOW     8'hFF
`define TMC_CNT_MAX      16'hFFFF

`endif

// ===== verilog/tmc_pkg.sv
// Types shared by the timer mode and capture/compare control block
// Assumes an APB4 master with 32-bit data and word-aligned registers
`default_nettype none

package tmc_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } tmc_apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tmc_apb_rsp_type;

  typedef struct packed {
    tmc_apb_rsp_type rsp;
    logic [3:0]      mode;
    logic [2:0]      ccctl;
    logic [7:0]      edges;
    logic [15:0]     cnt;
    logic [15:0]     cap0;
    logic [15:0]     cap1;
    logic [7:0]      div;
    logic [1:0]      pin1;
    logic [1:0]      pin2;
    logic [1:0]      pin3;
    logic            tout;
    logic            irq0;
    logic            irq1;
  } tmc_state_type;

endpackage

`default_nettype wire

// ===== verilog/tmc_timer.sv
// 16-bit timer with mode control, capture/compare control and APB registers
// Assumes capture pins are asynchronous and software obeys the stop-first rules
//
// Operation
// - Counter runs whenever operating-mode bits 3:2 are not both zero.
// - Mode 00 stops and clears the counter, no toggle, no interrupt.
// - 01 free-run, 10 clear on primary edge, 11 clear on first match.
// - Output toggles on either match; with bit 1 also on primary edge.
// - Running counter equal to first/second compare register raises first/second match irq.
// - Mode bit 0 is the overflow flag, one once overflow seen.
// - Wrap from FFFF to 0000 with first register FFFF sets overflow flag.
// - Mode register at FF60, byte or bit writable, resets to 00.
// - Control bit 2 makes second register compare (0) or capture (1).
// - Control bit 1 picks secondary edge (0) or reversed primary edge (1).
// - Control bit 0 makes first register compare (0) or capture (1).
// - Control register at FF62, byte or bit writable, resets to 00.
// - Primary pin set for both edges never triggers a capture.
// - Edge code 00 falling, 01 rising, 11 both, 10 none.
// - A compare register is checked every count; match raises its interrupt.
//
// Our own choice: the APB interface to the registers.
`default_nettype none
`include "tmc_consts.svh"

module tmc_timer (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rstn_i,
  // APB slave
  input  wire tmc_pkg::tmc_apb_req_type apb_req_i,
  output var  tmc_pkg::tmc_apb_rsp_type apb_rsp_o,
  // Capture and event pins
  input  wire logic                     primary_input_pin_i,
  input  wire logic                     secondary_input_pin_i,
  // Timer output and match interrupts
  output logic                          timer_output_pin_o,
  output logic                          first_match_irq_o,
  output logic                          second_match_irq_o
);

  tmc_pkg::tmc_state_type st_q;
  tmc_pkg::tmc_state_type st_d;

  logic        run;
  logic        tick;
  logic        pri_edge;
  logic        pri_cap;
  logic        pri_rev;
  logic        sec_edge;
  logic        match0;
  logic        match1;
  logic        wrap;
  logic        setup;
  logic        bus_wr;
  logic        hit;
  logic [15:0] idx;
  logic [1:0]  rise;
  logic [1:0]  fall;

  // Edge code decode; both edges may be refused for capture use
  function automatic logic edge_hit(input logic [1:0] code, input logic r,
                                    input logic f, input logic both_ok);
    logic res;
    res = 1'b0;
    case (code)
      `TMC_EDGE_FALL: res = f;
      `TMC_EDGE_RISE: res = r;
      `TMC_EDGE_BOTH: res = both_ok & (r | f);
      default:        res = 1'b0;
    endcase
    return res;
  endfunction

  // Merge a 16-bit register with byte lanes of a write
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  always_comb begin
    st_d = st_q;
    // Third stage only feeds edge detection, never the first stage
    st_d.pin1 = {secondary_input_pin_i, primary_input_pin_i};
    st_d.pin2 = st_q.pin1;
    st_d.pin3 = st_q.pin2;
    rise = st_q.pin2 & ~st_q.pin3;
    fall = ~st_q.pin2 & st_q.pin3;

    run = (st_q.mode[3:2] != `TMC_OP_STOP);
    pri_edge = edge_hit(st_q.edges[5:4], rise[0], fall[0], 1'b1);
    sec_edge = edge_hit(st_q.edges[7:6], rise[1], fall[1], 1'b1);
    pri_cap = edge_hit(st_q.edges[5:4], rise[0], fall[0], 1'b0);
    pri_rev = edge_hit(st_q.edges[5:4], fall[0], rise[0], 1'b0);

    // Count clock is an enable pulse; the divider idles while stopped
    st_d.div = run ? st_q.div + 8'h01 : 8'h00;
    case (st_q.edges[1:0])
      2'h0:    tick = run;
      2'h1:    tick = run && (st_q.div[1:0] == `TMC_DIV_MID);
      2'h2:    tick = run && (st_q.div == `TMC_DIV_SLOW);
      default: tick = run && pri_edge;
    endcase

    match0 = tick && !st_q.ccctl[`TMC_CAP0_BIT] && (st_q.cnt == st_q.cap0);
    match1 = tick && !st_q.ccctl[`TMC_CAP1_BIT] && (st_q.cnt == st_q.cap1);
    wrap = tick && (st_q.cnt == `TMC_CNT_MAX);
    st_d.irq0 = match0;
    st_d.irq1 = match1;

    // Toggle sources; nothing toggles while stopped
    if (match0 || match1 || (run && st_q.mode[`TMC_TOG_BIT] && pri_edge)) begin
      st_d.tout = ~st_q.tout;
    end

    if (!run) begin
      st_d.cnt = 16'h0000;
    end else if (st_q.mode[3:2] == `TMC_OP_CLR_EDGE && pri_edge) begin
      st_d.cnt = 16'h0000;
    end else if (tick) begin
      if (st_q.mode[3:2] == `TMC_OP_CLR_MATCH && st_q.cnt == st_q.cap0) begin
        st_d.cnt = 16'h0000;
      end else begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
    end

    // APB: answer one cycle after setup, zero wait in the access phase
    idx = apb_req_i.paddr[17:2];
    setup = apb_req_i.psel && !apb_req_i.penable;
    hit = (idx == `TMC_IDX_MODE) || (idx == `TMC_IDX_EDGE) || (idx == `TMC_IDX_CCCTL) ||
          (idx == `TMC_IDX_CAP0) || (idx == `TMC_IDX_CAP1) || (idx == `TMC_IDX_COUNT);
    bus_wr = apb_req_i.psel && apb_req_i.penable && st_q.rsp.pready && apb_req_i.pwrite && hit;
    st_d.rsp.pready = 1'b0;
    if (setup && !st_q.rsp.pready) begin
      st_d.rsp.pready = 1'b1;
      st_d.rsp.pslverr = !hit;
      case (idx)
        `TMC_IDX_MODE:  st_d.rsp.prdata = {28'h0000000, st_q.mode};
        `TMC_IDX_EDGE:  st_d.rsp.prdata = {24'h000000, st_q.edges};
        `TMC_IDX_CCCTL: st_d.rsp.prdata = {29'h00000000, st_q.ccctl};
        `TMC_IDX_CAP0:  st_d.rsp.prdata = {16'h0000, st_q.cap0};
        `TMC_IDX_CAP1:  st_d.rsp.prdata = {16'h0000, st_q.cap1};
        `TMC_IDX_COUNT: st_d.rsp.prdata = {16'h0000, st_q.cnt};
        default:        st_d.rsp.prdata = 32'h00000000;
      endcase
    end

    if (bus_wr && apb_req_i.pstrb[0]) begin
      case (idx)
        `TMC_IDX_MODE:  st_d.mode = apb_req_i.pwdata[3:0];
        `TMC_IDX_EDGE:  st_d.edges = apb_req_i.pwdata[7:0];
        `TMC_IDX_CCCTL: st_d.ccctl = apb_req_i.pwdata[2:0];
        default:        st_d.mode = st_d.mode;
      endcase
    end
    if (bus_wr && idx == `TMC_IDX_CAP0) begin
      st_d.cap0 = lane16(st_q.cap0, apb_req_i.pwdata, apb_req_i.pstrb);
    end
    if (bus_wr && idx == `TMC_IDX_CAP1) begin
      st_d.cap1 = lane16(st_q.cap1, apb_req_i.pwdata, apb_req_i.pstrb);
    end

    // Hardware set beats a software clear of the overflow flag
    if (wrap) begin
      st_d.mode[`TMC_OVF_BIT] = 1'b1;
    end

    // Captures beat a same-cycle software write of the same register
    if (run && st_q.ccctl[`TMC_CAP0_BIT] &&
        (st_q.ccctl[`TMC_TRIG_BIT] ? pri_rev : sec_edge)) begin
      st_d.cap0 = st_q.cnt;
    end
    if (run && st_q.ccctl[`TMC_CAP1_BIT] && pri_cap) begin
      st_d.cap1 = st_q.cnt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      st_q <= '0;
      st_q.mode <= `TMC_MODE_RST;
      st_q.ccctl <= `TMC_CCCTL_RST;
      st_q.edges <= `TMC_EDGE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp_o = st_q.rsp;
  assign timer_output_pin_o = st_q.tout;
  assign first_match_irq_o = st_q.irq0;
  assign second_match_irq_o = st_q.irq1;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  AST_STOP_CLEAR: assert property (
    (st_q.mode[3:2] == 2'h0) [*2] |-> st_q.cnt == 16'h0000)
    else $error("counter not cleared while stopped");

  AST_STOP_NO_IRQ: assert property (
    $past(st_q.mode[3:2]) == 2'h0 |-> !first_match_irq_o && !second_match_irq_o)
    else $error("interrupt while stopped");

  AST_RUN_COUNT: assert property (
    (st_q.mode[3:2] == 2'h1 && st_q.edges[1:0] == 2'h0) [*2]
      |-> st_q.cnt == $past(st_q.cnt) + 16'h0001)
    else $error("free running counter did not advance");

  AST_MATCH0_IRQ: assert property (
    match0 |=> first_match_irq_o ##1 !first_match_irq_o || match0)
    else $error("first match interrupt missing");

  AST_MATCH1_IRQ: assert property (
    tick && !st_q.ccctl[2] && st_q.cnt == st_q.cap1 |=> second_match_irq_o)
    else $error("second match interrupt missing");

  AST_CLR_MATCH: assert property (
    tick && st_q.mode[3:2] == 2'h3 && st_q.cnt == st_q.cap0 |=> st_q.cnt == 16'h0000)
    else $error("no clear on first match");

  AST_CLR_EDGE: assert property (
    st_q.mode[3:2] == 2'h2 && pri_edge |=> st_q.cnt == 16'h0000)
    else $error("no clear on primary edge");

  AST_OVF_SET: assert property (
    tick && st_q.cnt == 16'hFFFF && st_q.cap0 == 16'hFFFF |=> st_q.mode[0])
    else $error("overflow flag not set");

  AST_TOGGLE: assert property (
    (match0 || match1) && !(st_q.mode[1] && pri_edge)
      |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("output did not toggle on match");

  AST_NO_CAP_BOTH: assert property (
    st_q.edges[5:4] == 2'h3 && st_q.ccctl[2] && !bus_wr |=> $stable(st_q.cap1))
    else $error("capture on both edges");

  AST_CAP0: assert property (
    run && st_q.ccctl[1:0] == 2'h1 && sec_edge |=> st_q.cap0 == $past(st_q.cnt))
    else $error("secondary capture missing");

  AST_IRQ0_ONLY_MATCH: assert property (
    first_match_irq_o |-> $past(match0))
    else $error("first match interrupt without match");

  AST_IRQ1_ONLY_MATCH: assert property (
    second_match_irq_o |-> $past(match1))
    else $error("second match interrupt without match");

  AST_STOP_NO_TOGGLE: assert property (
    $past(st_q.mode[3:2]) == 2'h0 |-> $stable(timer_output_pin_o))
    else $error("output toggled while stopped");

  AST_CAP0_HOLD: assert property (
    !st_q.ccctl[0] && !bus_wr |=> $stable(st_q.cap0))
    else $error("compare register changed without write");

  AST_CAP1_HOLD: assert property (
    !st_q.ccctl[2] && !bus_wr |=> $stable(st_q.cap1))
    else $error("second compare register changed without write");

  AST_CAP1_CAPTURE: assert property (
    run && st_q.ccctl[2] && pri_cap |=> st_q.cap1 == $past(st_q.cnt))
    else $error("second register capture missing");

  AST_CAP0_REVERSE: assert property (
    run && st_q.ccctl[1:0] == 2'h3 && pri_rev |=> st_q.cap0 == $past(st_q.cnt))
    else $error("reverse phase capture missing");

  AST_CAP0_NO_IRQ: assert property (
    st_q.ccctl[0] |=> !first_match_irq_o)
    else $error("match interrupt from capture register");

  AST_CAP1_NO_IRQ: assert property (
    st_q.ccctl[2] |=> !second_match_irq_o)
    else $error("match interrupt from second capture register");

  AST_MODE_WRITE: assert property (
    bus_wr && apb_req_i.pstrb[0] && idx == `TMC_IDX_MODE && !wrap
      |=> st_q.mode == $past(apb_req_i.pwdata[3:0]))
    else $error("mode register write lost");

  AST_CTL_WRITE: assert property (
    bus_wr && apb_req_i.pstrb[0] && idx == `TMC_IDX_CCCTL
      |=> st_q.ccctl == $past(apb_req_i.pwdata[2:0]))
    else $error("control register write lost");

  AST_RST_VALUES: assert property (
    disable iff (1'b0) !rstn_i |=> st_q.mode == 4'h0 && st_q.ccctl == 3'h0)
    else $error("control registers not cleared by reset");

  AST_OVF_ONLY_WRAP: assert property (
    $rose(st_q.mode[0]) |-> $past(wrap || bus_wr))
    else $error("overflow flag set without wrap");

  AST_OVF_HOLD: assert property (
    st_q.mode[0] && !bus_wr |=> st_q.mode[0])
    else $error("overflow flag lost");

  AST_DIV_IDLE: assert property (
    !run |=> st_q.div == 8'h00)
    else $error("divider running while stopped");

  AST_ONE_ACCESS: assert property (
    apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("ready held for more than one cycle");

  AST_IDLE_NO_TOGGLE: assert property (
    !match0 && !match1 && !(run && st_q.mode[1] && pri_edge) |=> $stable(timer_output_pin_o))
    else $error("output toggled without event");

  AST_EDGE_TOGGLE: assert property (
    run && st_q.mode[1] && pri_edge && !match0 && !match1
      |=> timer_output_pin_o != $past(timer_output_pin_o))
    else $error("output did not toggle on primary edge");

  AST_PRI_PROHIBITED: assert property (
    st_q.edges[5:4] == 2'h2 |-> !pri_edge && !pri_cap)
    else $error("primary edge seen with prohibited code");

  AST_SEC_PROHIBITED: assert property (
    st_q.edges[7:6] == 2'h2 |-> !sec_edge)
    else $error("secondary edge seen with prohibited code");

  AST_FREE_ADVANCE: assert property (
    st_q.mode[3:2] == 2'h1 && tick |=> st_q.cnt == $past(st_q.cnt) + 16'h0001)
    else $error("free running counter cleared");

  AST_HOLD_NO_TICK: assert property (
    run && !tick && !(st_q.mode[3:2] == 2'h2 && pri_edge) |=> $stable(st_q.cnt))
    else $error("counter moved without count clock");

  AST_STOP_NO_CAPTURE: assert property (
    !run && !bus_wr |=> $stable(st_q.cap0) && $stable(st_q.cap1))
    else $error("capture while stopped");

  COV_MATCH0: cover property (match0 ##1 first_match_irq_o);
  COV_CAPTURE: cover property (run && st_q.ccctl[0] && sec_edge);
  COV_OVERFLOW: cover property (wrap ##1 st_q.mode[0]);
  COV_CLR_EDGE: cover property (st_q.mode[3:2] == 2'h2 && pri_edge);
  COV_CAP1: cover property (run && st_q.ccctl[2] && pri_cap);

endmodule

`default_nettype wire
